// ==== str_pkg.sv ====
// Constants and types shared by the segmented trigger recorder
package str_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam int ADDR_W = 20;
  localparam logic [19:0] REG_SEG_LIMIT = 20'h02724;
  localparam logic [19:0] REG_TRIG_STYLE = 20'h3107e;
  localparam logic [19:0] REG_TRIG_COUNT = 20'h310c9;
  localparam logic [19:0] REG_MODE = 20'h0251c;
  localparam logic [19:0] REG_TOTAL = 20'h02710;
  localparam logic [19:0] REG_SEG_LEN = 20'h0271a;
  localparam logic [19:0] REG_POST_LEN = 20'h02774;
  // ----------------------------------------
  // Reset values and encodings
  // ----------------------------------------
  localparam logic [31:0] SEG_LIMIT_RST = 32'h0000_0000;
  localparam logic TRIG_STYLE_RST = 1'b0;
  localparam logic [7:0] MODE_RST = 8'h02;
  localparam logic [7:0] MODE_STD_MULTI = 8'h02;
  localparam logic [7:0] MODE_FIFO_MULTI = 8'h20;
  localparam logic [31:0] TOTAL_RST = 32'h0000_1000;
  localparam logic [31:0] SEG_LEN_RST = 32'h0000_0400;
  localparam logic [31:0] POST_LEN_RST = 32'h0000_0300;
  // ----------------------------------------
  // Memory geometry
  // ----------------------------------------
  localparam int CNT_W = 48;
  localparam logic [31:0] MEM_SAMPLES = 32'h0200_0000;
  localparam logic [1:0] BYTE_SHIFT = 2'h1;
  localparam logic [31:0] PRE_MAX_1CH = 32'h0000_1ff0;
  localparam logic [31:0] PRE_MAX_2CH = 32'h0000_0ff8;
  localparam logic [31:0] PRE_MAX_4CH = 32'h0000_07fc;
  localparam logic [31:0] PRE_MAX_8CH = 32'h0000_03fc;
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_FILL = 5'b00010,
    ST_ARMED = 5'b00100,
    ST_POST = 5'b01000,
    ST_DONE = 5'b10000
  } str_state_e;
endpackage

// ==== str_trig_counter.sv ====
// Accepted non-forced trigger event counter
`timescale 1ns/1ps
module str_trig_counter
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic count_i,
  output logic [str_pkg::CNT_W-1:0] count_o
);
  import str_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } str_cnt_s;

  str_cnt_s s;
  str_cnt_s next_s;

  always_comb
  begin
    next_s = s;
    if (clear_i)
    begin
      next_s.cnt = '0;
    end
    else if (count_i)
    begin
      next_s.cnt = s.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign count_o = s.cnt;
endmodule

// ==== str_recorder.sv ====
// Segmented trigger recording control
`timescale 1ns/1ps
module str_recorder
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [str_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [63:0] reg_rdata_o,
  input wire logic [1:0] chan_sel_i,
  input wire logic acq_start_i,
  input wire logic acq_stop_i,
  input wire logic sample_valid_i,
  input wire logic trig_i,
  input wire logic force_trig_i,
  input wire logic trig_internal_i,
  input wire logic trig_out_en_i,
  output logic trig_out_o,
  output logic timestamp_strobe_o,
  output logic [31:0] pre_event_length_o,
  output logic pre_event_length_error_o,
  output logic mem_we_o,
  output logic [39:0] mem_addr_o,
  output logic running_o,
  output logic acq_done_o
);
  import str_pkg::*;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic [31:0] pre_limit(input logic [1:0] sel);
    case (sel)
      2'h0: pre_limit = PRE_MAX_1CH;
      2'h1: pre_limit = PRE_MAX_2CH;
      2'h2: pre_limit = PRE_MAX_4CH;
      default: pre_limit = PRE_MAX_8CH;
    endcase
  endfunction

  function automatic logic [39:0] to_bytes(input logic [31:0] n, input logic [1:0] sel);
    to_bytes = {8'h00, n} << (BYTE_SHIFT + {1'b0, sel});
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    str_state_e st;
    logic [31:0] seg_limit;
    logic style;
    logic [7:0] mode;
    logic [31:0] total;
    logic [31:0] seg_len;
    logic [31:0] post_len;
    logic [31:0] seg_cnt;
    logic [32:0] used;
    logic [31:0] pos;
    logic [31:0] fill;
    logic [31:0] postc;
    logic [39:0] base;
    logic tout;
    logic ts;
    logic done;
    logic err;
    logic we;
    logic [39:0] waddr;
    logic [63:0] rdata;
  } str_rec_s;

  str_rec_s s;
  str_rec_s next_s;
  logic [CNT_W-1:0] trig_count;
  logic [31:0] pre_len;
  logic [31:0] cap;
  logic [32:0] limit;
  logic accept;
  logic real_trig;
  logic active;
  logic seg_end;
  logic last_seg;
  logic [31:0] pos_inc;

  assign pre_len = s.seg_len - s.post_len;
  assign cap = MEM_SAMPLES >> chan_sel_i;
  assign limit = {1'b0, (s.total < cap) ? s.total : cap};
  assign accept = (s.st == ST_ARMED) && (trig_i || force_trig_i);
  assign real_trig = accept && trig_i;
  assign active = (s.st == ST_FILL) || (s.st == ST_ARMED) || (s.st == ST_POST);
  assign seg_end = (s.st == ST_POST) && sample_valid_i && (s.postc + 32'h1 >= s.post_len);
  assign last_seg = ((s.seg_limit != 32'h0) && (s.seg_cnt + 32'h1 == s.seg_limit))
    || ((s.mode == MODE_STD_MULTI) && (s.used + {1'b0, s.seg_len} + {1'b0, s.seg_len} > limit));
  assign pos_inc = (s.pos + 32'h1 >= s.seg_len) ? 32'h0 : s.pos + 32'h1;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  str_trig_counter u_cnt
  (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .clear_i(acq_start_i),
    .count_i(real_trig && !acq_start_i),
    .count_o(trig_count)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.ts = real_trig;
    next_s.err = (s.post_len > s.seg_len) || (pre_len > pre_limit(chan_sel_i));
    next_s.we = active && sample_valid_i;
    next_s.waddr = s.base + to_bytes(s.pos, chan_sel_i);
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        REG_SEG_LIMIT: next_s.seg_limit = reg_wdata_i;
        REG_TRIG_STYLE: next_s.style = reg_wdata_i[0];
        REG_MODE: next_s.mode = reg_wdata_i[7:0];
        REG_TOTAL: next_s.total = reg_wdata_i;
        REG_SEG_LEN: next_s.seg_len = reg_wdata_i;
        REG_POST_LEN: next_s.post_len = reg_wdata_i;
        default: next_s.mode = s.mode;
      endcase
    end
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        REG_SEG_LIMIT: next_s.rdata = {32'h0, s.seg_limit};
        REG_TRIG_STYLE: next_s.rdata = {63'h0, s.style};
        REG_MODE: next_s.rdata = {56'h0, s.mode};
        REG_TOTAL: next_s.rdata = {32'h0, s.total};
        REG_SEG_LEN: next_s.rdata = {32'h0, s.seg_len};
        REG_POST_LEN: next_s.rdata = {32'h0, s.post_len};
        REG_TRIG_COUNT: next_s.rdata = {16'h0, trig_count};
        default: next_s.rdata = 64'h0;
      endcase
    end
    case (s.st)
      ST_IDLE, ST_DONE:
      begin
        next_s.st = s.st;
      end
      ST_FILL:
      begin
        if (sample_valid_i)
        begin
          next_s.pos = pos_inc;
          next_s.fill = s.fill + 32'h1;
          if (s.fill + 32'h1 >= pre_len)
          begin
            next_s.st = ST_ARMED;
          end
        end
      end
      ST_ARMED:
      begin
        if (sample_valid_i)
        begin
          next_s.pos = pos_inc;
        end
        if (accept)
        begin
          next_s.st = ST_POST;
          next_s.postc = 32'h0;
          next_s.tout = trig_out_en_i && trig_internal_i;
        end
      end
      ST_POST:
      begin
        if (sample_valid_i)
        begin
          next_s.pos = pos_inc;
          next_s.postc = s.postc + 32'h1;
        end
        if (seg_end)
        begin
          next_s.seg_cnt = s.seg_cnt + 32'h1;
          next_s.used = s.used + {1'b0, s.seg_len};
          if (last_seg)
          begin
            next_s.st = ST_DONE;
            next_s.done = 1'b1;
            next_s.tout = 1'b0;
          end
          else
          begin
            next_s.base = s.base + to_bytes(s.seg_len, chan_sel_i);
            next_s.pos = 32'h0;
            next_s.fill = 32'h0;
            next_s.st = (pre_len == 32'h0) ? ST_ARMED : ST_FILL;
            next_s.tout = s.style && s.tout;
          end
        end
      end
      default:
      begin
        next_s.st = ST_IDLE;
      end
    endcase
    if (acq_stop_i && active)
    begin
      next_s.st = ST_DONE;
      next_s.done = 1'b1;
      next_s.tout = 1'b0;
    end
    if (acq_start_i)
    begin
      next_s.st = (pre_len == 32'h0) ? ST_ARMED : ST_FILL;
      next_s.seg_cnt = 32'h0;
      next_s.used = 33'h0;
      next_s.pos = 32'h0;
      next_s.fill = 32'h0;
      next_s.base = 40'h0;
      next_s.done = 1'b0;
      next_s.tout = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.st <= ST_IDLE;
      s.seg_limit <= SEG_LIMIT_RST;
      s.style <= TRIG_STYLE_RST;
      s.mode <= MODE_RST;
      s.total <= TOTAL_RST;
      s.seg_len <= SEG_LEN_RST;
      s.post_len <= POST_LEN_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign reg_rdata_o = s.rdata;
  assign trig_out_o = s.tout;
  assign timestamp_strobe_o = s.ts;
  assign pre_event_length_o = pre_len;
  assign pre_event_length_error_o = s.err;
  assign mem_we_o = s.we;
  assign mem_addr_o = s.waddr;
  assign running_o = active;
  assign acq_done_o = s.done;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence q_real;
    real_trig && !acq_start_i;
  endsequence
  sequence q_bump;
    trig_count == $past(trig_count) + 48'h1;
  endsequence
  property p_count_inc;
    @(posedge ref_clk_i) disable iff (rst_i) q_real |=> q_bump;
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("count did not follow trigger");
  property p_count_clear;
    @(posedge ref_clk_i) disable iff (rst_i) acq_start_i |=> trig_count == 48'h0;
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("count not cleared at start");
  property p_ts_one;
    @(posedge ref_clk_i) disable iff (rst_i) q_real |=> timestamp_strobe_o ##1 !timestamp_strobe_o;
  endproperty
  a_ts_one: assert property (p_ts_one) else $error("timestamp strobe not single");
  property p_tout_rise;
    @(posedge ref_clk_i) disable iff (rst_i)
      accept && trig_out_en_i && trig_internal_i && !acq_start_i && !acq_stop_i |=> trig_out_o;
  endproperty
  a_tout_rise: assert property (p_tout_rise) else $error("trigger output did not rise");
  property p_tout_fall;
    @(posedge ref_clk_i) disable iff (rst_i) seg_end && !s.style |=> !trig_out_o;
  endproperty
  a_tout_fall: assert property (p_tout_fall) else $error("trigger output stayed high");
  property p_limit_done;
    @(posedge ref_clk_i) disable iff (rst_i)
      seg_end && s.seg_limit != 32'h0 && s.seg_cnt + 32'h1 == s.seg_limit && !acq_start_i
      |=> acq_done_o && !running_o;
  endproperty
  a_limit_done: assert property (p_limit_done) else $error("limit reached but still running");
  property p_infinite;
    @(posedge ref_clk_i) disable iff (rst_i)
      seg_end && s.seg_limit == 32'h0 && s.mode == MODE_FIFO_MULTI && !acq_stop_i && !acq_start_i
      |=> running_o;
  endproperty
  a_infinite: assert property (p_infinite) else $error("unlimited run stopped");
  property p_base_step;
    @(posedge ref_clk_i) disable iff (rst_i)
      seg_end && !last_seg && !acq_start_i && !acq_stop_i
      |=> s.base == $past(s.base) + to_bytes($past(s.seg_len), $past(chan_sel_i));
  endproperty
  a_base_step: assert property (p_base_step) else $error("segment base step wrong");
  property p_no_accept;
    @(posedge ref_clk_i) disable iff (rst_i)
      s.st != ST_ARMED && !acq_start_i |=> trig_count == $past(trig_count);
  endproperty
  a_no_accept: assert property (p_no_accept) else $error("trigger counted while not armed");
endmodule

// ==== str_host_model.sv ====
// Host driver model that reaches the recorder registers
`timescale 1ns/1ps
module str_host_model
(
  input wire logic ref_clk_i,
  output logic [str_pkg::ADDR_W-1:0] reg_addr_o,
  output logic [31:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [63:0] reg_rdata_i
);
  import str_pkg::*;
  initial
  begin
    reg_addr_o = '0;
    reg_wdata_o = '0;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // Write one register; callers keep sizes in steps of four
  task automatic put(input logic [19:0] addr, input logic [31:0] data);
    @(posedge ref_clk_i);
    reg_addr_o <= addr;
    reg_wdata_o <= data;
    reg_wr_o <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~addr;
    reg_wdata_o <= ~data;
  endtask
  // Read one register as a single 64-bit access
  task automatic get(input logic [19:0] addr, output logic [63:0] data);
    @(posedge ref_clk_i);
    reg_addr_o <= addr;
    reg_rd_o <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~addr;
    @(posedge ref_clk_i);
    data = reg_rdata_i;
  endtask
endmodule

// ==== test_segmented_trigger_recording_control.sv ====
// Self-checking bench for the segmented trigger recorder
`timescale 1ns/1ps
module test_segmented_trigger_recording_control;
  import str_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [63:0] reg_rdata_o;
  logic [1:0] chan_sel_i = 2'h0;
  logic acq_start_i = 1'b0;
  logic acq_stop_i = 1'b0;
  logic sample_valid_i = 1'b0;
  logic trig_i = 1'b0;
  logic force_trig_i = 1'b0;
  // Internal trigger source at start; test 4 clears it and also drives one forced trigger
  logic trig_internal_i = 1'b1;
  logic trig_out_en_i = 1'b1;
  logic trig_out_o;
  logic timestamp_strobe_o;
  logic pre_event_length_error_o;
  logic mem_we_o;
  logic running_o;
  logic acq_done_o;
  logic [31:0] pre_event_length_o;
  logic [39:0] mem_addr_o;
  int err_total = 0;
  int checks = 0;
  int ts_n = 0;
  int we_n = 0;
  int seed;
  longint base_m = 0;
  longint span = 16;
  longint step = 2;
  logic [63:0] rd;
  logic [19:0] r_addr [8] = '{REG_SEG_LIMIT, REG_TRIG_STYLE, REG_TRIG_COUNT, REG_MODE, REG_TOTAL,
    REG_SEG_LEN, REG_POST_LEN, 20'h00abc};
  logic [63:0] r_rst [8] = '{64'(SEG_LIMIT_RST), 64'(TRIG_STYLE_RST), 64'h0, 64'(MODE_RST),
    64'(TOTAL_RST), 64'(SEG_LEN_RST), 64'(POST_LEN_RST), 64'h0};

  initial
  begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  str_recorder dut_u (.ref_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .chan_sel_i, .acq_start_i, .acq_stop_i, .sample_valid_i, .trig_i, .force_trig_i,
    .trig_internal_i, .trig_out_en_i, .trig_out_o, .timestamp_strobe_o, .pre_event_length_o,
    .pre_event_length_error_o, .mem_we_o, .mem_addr_o, .running_o, .acq_done_o);

  str_host_model host_u (.ref_clk_i, .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
    .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic bit in_seg(input logic [39:0] a);
    longint d;
    d = longint'(a) - base_m;
    return d >= 0 && d < span && d % step == 0;
  endfunction

  always @(posedge ref_clk_i)
  begin
    if (timestamp_strobe_o === 1'b1)
      ts_n++;
    if (mem_we_o === 1'b1)
    begin
      we_n++;
      chk(64'(in_seg(mem_addr_o)), 64'h1);
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000)
      @(posedge ref_clk_i);
    err_total++;
    summarize();
  end

  // ----------------------------------------
  // Stimulus tasks
  // ----------------------------------------
  task automatic pulse_valid(input int n);
    repeat (n)
    begin
      @(posedge ref_clk_i);
      sample_valid_i <= 1'b1;
    end
    @(posedge ref_clk_i);
    sample_valid_i <= 1'b0;
  endtask

  task automatic pulse_trig();
    @(posedge ref_clk_i);
    trig_i <= 1'b1;
    @(posedge ref_clk_i);
    trig_i <= 1'b0;
  endtask

  task automatic start_acq(input int sel);
    @(posedge ref_clk_i);
    chan_sel_i <= 2'(sel);
    acq_start_i <= 1'b1;
    @(posedge ref_clk_i);
    acq_start_i <= 1'b0;
    base_m = 0;
    span = 64'(16) << sel;
    step = 64'(2) << sel;
  endtask

  // One segment of four pre and four post samples
  task automatic seg(input bit forced, input bit hold, input bit last);
    pulse_valid(4);
    if (forced)
      force_trig_i <= 1'b1;
    else
      trig_i <= 1'b1;
    @(posedge ref_clk_i);
    trig_i <= 1'b0;
    force_trig_i <= 1'b0;
    #1;
    if (!forced)
    begin
      chk(trig_out_o, 64'(trig_out_en_i && trig_internal_i));
      chk(timestamp_strobe_o, 64'h1);
    end
    pulse_valid(4);
    repeat (2)
      @(posedge ref_clk_i);
    #1;
    if (!forced)
      chk(trig_out_o, 64'(hold && !last));
    chk(acq_done_o, 64'(last));
    base_m += span;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    seed = $urandom(32);
    repeat (6)
      @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      host_u.get(r_addr[i], rd);
      chk(rd, r_rst[i]);
    end
    chk(pre_event_length_o, 64'h100);
    $display("test 1 done");
    host_u.put(REG_SEG_LEN, 32'h8);
    host_u.put(REG_POST_LEN, 32'h4);
    host_u.put(REG_TOTAL, 32'h20);
    #1;
    chk(pre_event_length_o, 64'h4);
    start_acq($urandom % 4);
    for (int i = 0; i < 4; i++)
      seg(1'b0, 1'b0, i == 3);
    chk(running_o, 64'h0);
    pulse_trig();
    host_u.get(REG_TRIG_COUNT, rd);
    chk(rd, 64'h4);
    chk(pre_event_length_error_o, 64'h0);
    $display("test 2 done");
    host_u.put(REG_MODE, 32'(MODE_FIFO_MULTI));
    host_u.put(REG_SEG_LIMIT, 32'h2);
    host_u.put(REG_TRIG_STYLE, 32'h1);
    start_acq($urandom % 4);
    pulse_trig();
    host_u.get(REG_TRIG_COUNT, rd);
    chk(rd, 64'h0);
    seg(1'b0, 1'b1, 1'b0);
    seg(1'b0, 1'b1, 1'b1);
    host_u.get(REG_TRIG_COUNT, rd);
    chk(rd, 64'h2);
    $display("test 3 done");
    host_u.put(REG_SEG_LIMIT, 32'h0);
    host_u.put(REG_TRIG_STYLE, 32'h0);
    start_acq($urandom % 4);
    trig_out_en_i <= 1'b0;
    seg(1'b0, 1'b0, 1'b0);
    @(posedge ref_clk_i);
    trig_out_en_i <= 1'b1;
    trig_internal_i <= 1'b0;
    seg(1'b0, 1'b0, 1'b0);
    host_u.get(REG_TRIG_COUNT, rd);
    chk(rd, 64'h2);
    seg(1'b1, 1'b0, 1'b0);
    @(posedge ref_clk_i);
    acq_stop_i <= 1'b1;
    @(posedge ref_clk_i);
    acq_stop_i <= 1'b0;
    repeat (2)
      @(posedge ref_clk_i);
    #1;
    chk(acq_done_o, 64'h1);
    host_u.get(REG_TRIG_COUNT, rd);
    chk(rd, 64'h2);
    chk(64'(ts_n), 64'h8);
    chk(64'(we_n), 64'd72);
    $display("test 4 done");
    host_u.put(REG_POST_LEN, 32'hc);
    repeat (2)
      @(posedge ref_clk_i);
    #1;
    chk(pre_event_length_error_o, 64'h1);
    $display("test 5 done");
    summarize();
  end
endmodule
